/* File: hdl/dbg_link.sv */
// Purpose: on-chip debug unit link end and debug mode control
// Assumes: srst covers power-on, brownout and reset pin
// Notes:   command set lives outside; it drives the request ports
`timescale 1ns/1ps
module dbg_link
	import dbg_link_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 srst,
	input  wire logic                 debug_serial_pin_in,
	output logic                      debug_serial_pin_out,
	output logic                      debug_serial_pin_oe,
	output logic      [DATA_BITS-1:0] rx_data,
	output logic                      rx_valid,
	input  wire logic [DATA_BITS-1:0] tx_data,
	input  wire logic                 tx_valid,
	output logic                      tx_ready,
	output logic                      cmd_abort,
	output logic                      baud_locked,
	input  wire logic                 ctrl_wr,
	input  wire logic                 debug_mode_request_bit,
	output logic                      debug_mode,
	input  wire logic                 breakpoint_en,
	input  wire logic                 break_instruction,
	input  wire logic                 match_break_en,
	input  wire logic                 countdown_break_en,
	input  wire logic [CNT_W-1:0]     prog_counter,
	input  wire logic                 counter_wr,
	input  wire logic [CNT_W-1:0]     counter_wdata,
	output logic      [CNT_W-1:0]     debug_counter,
	input  wire logic                 stop_mode,
	input  wire logic                 halt_mode,
	output logic                      halt_exit,
	input  wire logic                 exec_req,
	output logic                      exec_grant,
	output logic                      fetch_stop,
	output logic                      periph_run,
	input  wire logic                 wdt_enable,
	output logic                      wdt_refresh,
	output logic                      sys_reset_req
);

	// line synchroniser, idles high like the pulled-up pin
	logic sync1_reg;
	logic sync2_reg;
	logic prev_reg;
	wire  rx_level = sync2_reg;
	wire  fall     = prev_reg && !sync2_reg;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			prev_reg  <= 1'b1;
		end else begin
			sync1_reg <= debug_serial_pin_in;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	link_state_t          state_reg, state_next;
	logic [BIT_PER_W-1:0] tmr_reg, tmr_next;
	logic [2:0]           bit_reg, bit_next;
	logic [DATA_BITS-1:0] sh_reg, sh_next;
	logic [12:0]          err_reg, err_next;
	logic [LOW_CNT_W-1:0] low_reg;
	logic [DATA_BITS-1:0] rxd_reg;
	logic                 rxv_reg, rxv_next;
	logic                 abort_reg, abort_next;
	logic                 tx_start;

	wire [BIT_PER_W-1:0] period;
	wire                 locked;
	wire                 tx_drive, tx_busy, tx_done, tx_coll;
	wire                 unit_clear = (state_reg == LK_ERR) ||
		(state_reg == LK_HOLD);
	wire                 tmr_half = (tmr_reg == (period >> 1));
	wire                 tmr_full = (tmr_reg == period - 10'h001);
	wire [LOW_CNT_W-1:0] brk_lim = LOW_CNT_W'(period) *
		LOW_CNT_W'(BREAK_BITS);
	wire                 break_seen = locked && (low_reg >= brk_lim);

	dbg_autobaud u_baud (
		.core_clk   (core_clk),
		.srst       (srst),
		.rx_level   (rx_level),
		.clear      (unit_clear),
		.bit_period (period),
		.locked     (locked)
	);

	dbg_char_tx u_tx (
		.core_clk   (core_clk),
		.srst       (srst),
		.bit_period (period),
		.start      (tx_start),
		.tx_byte    (tx_data),
		.rx_level   (rx_level),
		.drive_low  (tx_drive),
		.busy       (tx_busy),
		.done       (tx_done),
		.collision  (tx_coll)
	);

	// continuous low run, counted in system clocks
	always_ff @(posedge core_clk) begin
		if (srst || rx_level || !locked || unit_clear) begin
			low_reg <= '0;
		end else if (low_reg != {LOW_CNT_W{1'b1}}) begin
			low_reg <= low_reg + 14'h0001;
		end
	end

	// transmit only while the receiver is quiet
	assign tx_ready = (state_reg == LK_IDLE) && locked && rx_level &&
		!tx_busy;
	assign tx_start = tx_ready && tx_valid;

	always_comb begin
		state_next = state_reg;
		tmr_next   = tmr_reg + 10'h001;
		bit_next   = bit_reg;
		sh_next    = sh_reg;
		err_next   = err_reg;
		rxv_next   = 1'b0;
		abort_next = 1'b0;
		case (state_reg)
			LK_IDLE: begin
				tmr_next = '0;
				if (tx_start) begin
					state_next = LK_TX;
				end else if (locked && fall) begin
					state_next = LK_START;
				end
			end
			LK_START: begin
				if (tmr_half) begin
					tmr_next   = '0;
					bit_next   = 3'h0;
					state_next = rx_level ? LK_IDLE : LK_DATA;
				end
			end
			LK_DATA: begin
				if (tmr_full) begin
					tmr_next = '0;
					// mid bit sample, lsb arrives first
					sh_next  = {rx_level, sh_reg[7:1]};
					bit_next = bit_reg + 3'h1;
					if (bit_reg == 3'h7) begin
						state_next = LK_STOP;
					end
				end
			end
			LK_STOP: begin
				if (tmr_full) begin
					tmr_next = '0;
					if (rx_level) begin
						rxv_next   = 1'b1;
						state_next = LK_IDLE;
					end else begin
						state_next = LK_ERR;
						abort_next = 1'b1;
					end
				end
			end
			LK_TX: begin
				if (tx_coll) begin
					state_next = LK_ERR;
					abort_next = 1'b1;
				end else if (tx_done) begin
					state_next = LK_IDLE;
				end
			end
			LK_ERR: begin
				if (err_reg == BREAK_TX_CLKS - 13'h0001) begin
					state_next = LK_HOLD;
				end
				err_next = err_reg + 13'h0001;
			end
			// unit held until the host lets the line go high
			LK_HOLD: begin
				if (rx_level) begin
					state_next = LK_IDLE;
				end
			end
			default: state_next = LK_IDLE;
		endcase
		if (break_seen && (state_reg != LK_ERR) &&
			(state_reg != LK_HOLD)) begin
			state_next = LK_ERR;
			abort_next = 1'b1;
		end
		if (state_next == LK_ERR && state_reg != LK_ERR) begin
			err_next = 13'h0000;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_reg <= LK_IDLE;
			tmr_reg   <= '0;
			bit_reg   <= 3'h0;
			sh_reg    <= 8'h00;
			err_reg   <= 13'h0000;
			rxv_reg   <= 1'b0;
			abort_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			tmr_reg   <= tmr_next;
			bit_reg   <= bit_next;
			sh_reg    <= sh_next;
			err_reg   <= err_next;
			rxv_reg   <= rxv_next;
			abort_reg <= abort_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rxd_reg <= 8'h00;
		end else if (rxv_next) begin
			rxd_reg <= sh_reg;
		end
	end

	// open drain: only ever pull low
	assign debug_serial_pin_out = 1'b0;
	assign debug_serial_pin_oe  = tx_drive ||
		(state_reg == LK_ERR);
	assign rx_data     = rxd_reg;
	assign rx_valid    = rxv_reg;
	assign cmd_abort   = abort_reg;
	assign baud_locked = locked;

	// debug mode control
	logic             dbg_reg, dbg_next;
	logic [1:0]       strap_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic             halt_x_reg;
	logic             sysrst_reg;

	// strap sample once the synchroniser holds a post-reset level
	always_ff @(posedge core_clk) begin
		if (srst) begin
			strap_reg <= 2'h0;
		end else if (strap_reg != 2'h3) begin
			strap_reg <= strap_reg + 2'h1;
		end
	end

	wire strap_hit = (strap_reg == STRAP_SAMPLE) && !rx_level;
	wire req_set   = ctrl_wr && debug_mode_request_bit;
	wire req_clr   = ctrl_wr && !debug_mode_request_bit;
	wire brk_hit   = breakpoint_en && break_instruction;
	wire match_hit = match_break_en && !dbg_reg &&
		(prog_counter == cnt_reg);
	wire cd_run    = countdown_break_en && !dbg_reg && (cnt_reg != CNT_RST);
	wire cd_hit    = cd_run && (cnt_reg == 16'h0001);
	wire enter     = req_set || brk_hit || match_hit || cd_hit ||
		strap_hit;

	// entry beats a clear arriving in the same cycle
	always_comb begin
		dbg_next = dbg_reg;
		if (enter) begin
			dbg_next = 1'b1;
		end else if (req_clr) begin
			dbg_next = 1'b0;
		end
	end

	// link errors and breaks leave debug mode untouched
	always_ff @(posedge core_clk) begin
		if (srst) begin
			dbg_reg <= 1'b0;
		end else begin
			dbg_reg <= dbg_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cnt_reg <= CNT_RST;
		end else if (counter_wr) begin
			cnt_reg <= counter_wdata;
		end else if (cd_run) begin
			cnt_reg <= cnt_reg - 16'h0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			halt_x_reg <= 1'b0;
			sysrst_reg <= 1'b0;
		end else begin
			halt_x_reg <= enter && !dbg_reg && halt_mode;
			sysrst_reg <= stop_mode && !rx_level;
		end
	end

	assign debug_mode    = dbg_reg;
	assign debug_counter = cnt_reg;
	assign halt_exit     = halt_x_reg;
	assign sys_reset_req = sysrst_reg;
	assign fetch_stop    = dbg_reg && !exec_req;
	assign exec_grant    = dbg_reg && exec_req;
	// debug mode never gates the clock, only stop mode does
	assign periph_run    = !stop_mode;
	assign wdt_refresh   = dbg_reg && wdt_enable;

endmodule // dbg_link

/* File: hdl/dbg_link_pkg.sv */
// Purpose: shared constants and types of the single pin debug link
// Assumes: one system clock, synchronous active high reset
// Notes:   widths sized for bit rates down to clock / 512
package dbg_link_pkg;

	localparam int          DATA_BITS     = 8;
	localparam int          BIT_PER_W     = 10;
	localparam int          LOW_CNT_W     = 14;
	localparam int          CNT_W         = 16;
	// longest low run of the rate character: 8 bits at clock / 512
	localparam logic [12:0] AB_LOW_MAX    = 13'h1000;
	localparam logic [7:0]  AB_CHAR       = 8'h80;
	// answer to any link error: low for this many system clocks
	localparam logic [12:0] BREAK_TX_CLKS = 13'h1000;
	localparam logic [3:0]  BREAK_BITS    = 4'hA;
	localparam logic [3:0]  FRAME_BITS    = 4'hA;
	localparam logic [15:0] CNT_RST       = 16'h0000;
	localparam logic [1:0]  STRAP_SAMPLE  = 2'h2;

	typedef enum logic [3:0] {
		AB_IDLE = 4'h1,
		AB_MEAS = 4'h2,
		AB_OVF  = 4'h4,
		AB_LOCK = 4'h8
	} ab_state_t;

	typedef enum logic [6:0] {
		LK_IDLE  = 7'h01,
		LK_START = 7'h02,
		LK_DATA  = 7'h04,
		LK_STOP  = 7'h08,
		LK_TX    = 7'h10,
		LK_ERR   = 7'h20,
		LK_HOLD  = 7'h40
	} link_state_t;

endpackage

/* File: hdl/dbg_autobaud.sv */
// Purpose: measures the low run of the first character, yields bit period
// Assumes: rx_level already synchronised to core_clk
// Notes:   clear returns to idle; period is the low run divided by eight
`timescale 1ns/1ps
module dbg_autobaud
	import dbg_link_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 srst,
	input  wire logic                 rx_level,
	input  wire logic                 clear,
	output logic      [BIT_PER_W-1:0] bit_period,
	output logic                      locked
);

	ab_state_t            state_reg, state_next;
	logic [12:0]          meas_reg, meas_next;
	logic [BIT_PER_W-1:0] per_reg, per_next;

	always_comb begin
		state_next = state_reg;
		meas_next  = meas_reg;
		per_next   = per_reg;
		case (state_reg)
			AB_IDLE: begin
				if (!rx_level) begin
					meas_next  = 13'h0001;
					state_next = AB_MEAS;
				end
			end
			AB_MEAS: begin
				if (rx_level) begin
					// eight bit times low, so period is a shift by three
					per_next   = (meas_reg[12:3] == '0) ? 10'h001 :
						meas_reg[12:3];
					state_next = AB_LOCK;
				end else if (meas_reg == AB_LOW_MAX) begin
					state_next = AB_OVF;
				end else begin
					meas_next = meas_reg + 13'h0001;
				end
			end
			// overflow: nothing loaded, back to reset once line is high
			AB_OVF: begin
				if (rx_level) begin
					state_next = AB_IDLE;
				end
			end
			AB_LOCK: state_next = AB_LOCK;
			default: state_next = AB_IDLE;
		endcase
		if (clear) begin
			state_next = AB_IDLE;
			per_next   = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_reg <= AB_IDLE;
			meas_reg  <= 13'h0000;
			per_reg   <= '0;
		end else begin
			state_reg <= state_next;
			meas_reg  <= meas_next;
			per_reg   <= per_next;
		end
	end

	assign bit_period = per_reg;
	assign locked     = (state_reg == AB_LOCK);

endmodule // dbg_autobaud

/* File: hdl/dbg_char_tx.sv */
// Purpose: sends one framed character on the open drain line
// Assumes: rx_level is the synchronised line level
// Notes:   line level checked mid bit while released, reports collision
`timescale 1ns/1ps
module dbg_char_tx
	import dbg_link_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 srst,
	input  wire logic [BIT_PER_W-1:0] bit_period,
	input  wire logic                 start,
	input  wire logic [DATA_BITS-1:0] tx_byte,
	input  wire logic                 rx_level,
	output logic                      drive_low,
	output logic                      busy,
	output logic                      done,
	output logic                      collision
);

	logic [9:0]           shift_reg, shift_next;
	logic [3:0]           bit_reg, bit_next;
	logic [BIT_PER_W-1:0] tmr_reg, tmr_next;
	logic                 busy_reg, busy_next;
	logic                 drv_reg, drv_next;
	logic                 done_next, coll_next;
	logic                 done_reg, coll_reg;
	wire                  mid_bit = (tmr_reg == (bit_period >> 1));
	wire                  bit_end = (tmr_reg == bit_period - 10'h001);

	always_comb begin
		shift_next = shift_reg;
		bit_next   = bit_reg;
		tmr_next   = tmr_reg;
		busy_next  = busy_reg;
		drv_next   = drv_reg;
		done_next  = 1'b0;
		coll_next  = 1'b0;
		if (!busy_reg) begin
			if (start) begin
				// stop, data lsb first, start
				shift_next = {1'b1, tx_byte, 1'b0};
				bit_next   = 4'h0;
				tmr_next   = '0;
				busy_next  = 1'b1;
				drv_next   = 1'b1;
			end
		end else if (mid_bit && shift_reg[0] && !rx_level) begin
			coll_next = 1'b1;
			busy_next = 1'b0;
			drv_next  = 1'b0;
		end else if (bit_end) begin
			tmr_next = '0;
			if (bit_reg == FRAME_BITS - 4'h1) begin
				busy_next = 1'b0;
				drv_next  = 1'b0;
				done_next = 1'b1;
			end else begin
				shift_next = {1'b1, shift_reg[9:1]};
				bit_next   = bit_reg + 4'h1;
				drv_next   = !shift_reg[1];
			end
		end else begin
			tmr_next = tmr_reg + 10'h001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			shift_reg <= 10'h3FF;
			bit_reg   <= 4'h0;
			tmr_reg   <= '0;
			busy_reg  <= 1'b0;
			drv_reg   <= 1'b0;
			done_reg  <= 1'b0;
			coll_reg  <= 1'b0;
		end else begin
			shift_reg <= shift_next;
			bit_reg   <= bit_next;
			tmr_reg   <= tmr_next;
			busy_reg  <= busy_next;
			drv_reg   <= drv_next;
			done_reg  <= done_next;
			coll_reg  <= coll_next;
		end
	end

	assign drive_low = drv_reg;
	assign busy      = busy_reg;
	assign done      = done_reg;
	assign collision = coll_reg;

endmodule // dbg_char_tx

/* File: dv/dbg_link_assertions.sv */
// Purpose: port checks of the debug link
// Assumes: bound to dbg_link, one clock
// Notes:   disabled while srst is high
`timescale 1ns/1ps
module dbg_link_assertions
	import dbg_link_pkg::*;
(
	input wire logic             core_clk,
	input wire logic             srst,
	input wire logic             debug_serial_pin_in,
	input wire logic             debug_serial_pin_out,
	input wire logic             debug_serial_pin_oe,
	input wire logic             tx_valid,
	input wire logic             tx_ready,
	input wire logic             cmd_abort,
	input wire logic             baud_locked,
	input wire logic             ctrl_wr,
	input wire logic             debug_mode_request_bit,
	input wire logic             debug_mode,
	input wire logic             breakpoint_en,
	input wire logic             break_instruction,
	input wire logic             match_break_en,
	input wire logic             countdown_break_en,
	input wire logic [CNT_W-1:0] prog_counter,
	input wire logic [CNT_W-1:0] debug_counter,
	input wire logic             stop_mode,
	input wire logic             halt_mode,
	input wire logic             halt_exit,
	input wire logic             exec_req,
	input wire logic             fetch_stop,
	input wire logic             periph_run,
	input wire logic             wdt_enable,
	input wire logic             wdt_refresh,
	input wire logic             sys_reset_req
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	property p_open; debug_serial_pin_out == 1'b0; endproperty
	a_open: assert property (p_open) else $error("pin driven high");
	property p_tx; tx_valid && tx_ready |=> debug_serial_pin_oe; endproperty
	a_tx: assert property (p_tx) else $error("no start bit");
	property p_wr; ctrl_wr && debug_mode_request_bit |=> debug_mode; endproperty
	a_wr: assert property (p_wr) else $error("no entry on write");
	property p_exit; ctrl_wr && !debug_mode_request_bit && !break_instruction
		&& !match_break_en && !countdown_break_en |=> !debug_mode; endproperty
	a_exit: assert property (p_exit) else $error("no exit");
	property p_brk; break_instruction && breakpoint_en |=> debug_mode; endproperty
	a_brk: assert property (p_brk) else $error("break ignored");
	property p_match; match_break_en && !debug_mode
		&& prog_counter == debug_counter |=> debug_mode; endproperty
	a_match: assert property (p_match) else $error("match ignored");
	property p_fetch; fetch_stop == (debug_mode && !exec_req); endproperty
	a_fetch: assert property (p_fetch) else $error("fetch stop wrong");
	property p_periph; periph_run == !stop_mode; endproperty
	a_periph: assert property (p_periph) else $error("periph run");
	property p_wdt; wdt_refresh == (debug_mode && wdt_enable); endproperty
	a_wdt: assert property (p_wdt) else $error("refresh wrong");
	property p_halt; $rose(debug_mode) && $past(halt_mode)
		|-> ##[0:1] halt_exit; endproperty
	a_halt: assert property (p_halt) else $error("halt not left");
	property p_sys; (stop_mode && !debug_serial_pin_in)[*5]
		|-> sys_reset_req; endproperty
	a_sys: assert property (p_sys) else $error("no system reset");
	property p_abort; cmd_abort |-> ##[0:2] debug_serial_pin_oe[*8]; endproperty
	a_abort: assert property (p_abort) else $error("no break sent");
	property p_unlock; cmd_abort |-> ##[0:3] !baud_locked; endproperty
	a_unlock: assert property (p_unlock) else $error("rate kept");
	property p_keep; cmd_abort && debug_mode && !ctrl_wr |=> debug_mode;
	endproperty
	a_keep: assert property (p_keep) else $error("mode lost");
endmodule // dbg_link_assertions

/* File: dv/dbg_host_model.sv */
// Purpose: host debugger at the far end of the debug pin
// Assumes: wire pulled up, host only pulls low
// Notes:   moves on the falling edge of core_clk
`timescale 1ns/1ps
module dbg_host_model (
	input  wire logic core_clk,
	input  wire logic line,
	output logic      host_low
);
	initial host_low = 1'b0;
	task automatic hold_low(input int n);
		host_low = 1'b1;
		repeat (n) @(negedge core_clk);
		host_low = 1'b0;
	endtask
	// start low, lsb first, stop released
	task automatic send_byte(input logic [7:0] b, input int p);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			host_low = !f[i];
			repeat (p) @(negedge core_clk);
		end
	endtask
	// silent while the device sends
	task automatic recv_byte(input int p, output logic [7:0] b,
			output logic ok);
		int k;
		b = 8'h00;
		for (k = 0; k < 400 && line; k++)
			@(negedge core_clk);
		repeat (p / 2) @(negedge core_clk);
		ok = (k < 400) && !line;
		for (int i = 0; i < 8; i++) begin
			repeat (p) @(negedge core_clk);
			b[i] = line;
		end
		repeat (p) @(negedge core_clk);
		ok = ok && line;
	endtask
endmodule // dbg_host_model

/* File: dv/tb_dbg_link.sv */
// Purpose: self-checking bench of the debug link
// Assumes: host model on the pin, pull-up on the wire
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
module tb_dbg_link;
	import dbg_link_pkg::*;
	logic                 core_clk, srst, host_low, debug_serial_pin_out;
	logic                 debug_serial_pin_oe, rx_valid, tx_valid, tx_ready;
	logic                 cmd_abort, baud_locked, ctrl_wr, debug_mode;
	logic                 debug_mode_request_bit, breakpoint_en, halt_exit;
	logic                 break_instruction, match_break_en, counter_wr;
	logic                 countdown_break_en, stop_mode, halt_mode, exec_req;
	logic                 exec_grant, fetch_stop, periph_run, wdt_enable;
	logic                 wdt_refresh, sys_reset_req;
	logic [DATA_BITS-1:0] rx_data, tx_data;
	logic [CNT_W-1:0]     prog_counter, counter_wdata, debug_counter;
	wire logic            debug_serial_pin_in;
	int                   failures, comparisons;
	assign debug_serial_pin_in = !(debug_serial_pin_oe || host_low);
	dbg_link u_dbg_link (.core_clk, .srst, .debug_serial_pin_in,
		.debug_serial_pin_out, .debug_serial_pin_oe, .rx_data, .rx_valid,
		.tx_data, .tx_valid, .tx_ready, .cmd_abort, .baud_locked, .ctrl_wr,
		.debug_mode_request_bit, .debug_mode, .breakpoint_en,
		.break_instruction, .match_break_en, .countdown_break_en,
		.prog_counter, .counter_wr, .counter_wdata, .debug_counter,
		.stop_mode, .halt_mode, .halt_exit, .exec_req, .exec_grant,
		.fetch_stop, .periph_run, .wdt_enable, .wdt_refresh, .sys_reset_req);
	dbg_host_model u_dbg_host_model (.core_clk, .line(debug_serial_pin_in),
		.host_low);
	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;
	task automatic chk(input string what, input logic [15:0] exp,
			input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run;
		if (failures == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	task automatic reset;
		srst = 1'b1;
		cyc(3);
		srst = 1'b0;
	endtask
	task automatic enter;
		debug_mode_request_bit = 1'b1;
		pulse(ctrl_wr);
	endtask
	task automatic leave;
		debug_mode_request_bit = 1'b0;
		pulse(ctrl_wr);
		cyc(1);
		chk("debug_exit", 0, debug_mode);
	endtask
	task automatic t_lock(input int p);
		u_dbg_host_model.send_byte(AB_CHAR, p);
		cyc(4);
		chk("baud_locked", 1, baud_locked);
	endtask
	task automatic t_rx(input logic [7:0] b, input int p);
		logic [7:0] got;
		logic       seen;
		seen = 1'b0;
		got = 8'h00;
		fork
			u_dbg_host_model.send_byte(b, p);
			for (int k = 0; k < 12 * p && !seen; k++) begin
				cyc(1);
				if (rx_valid) begin
					seen = 1'b1;
					got = rx_data;
				end
			end
		join
		chk("rx_valid", 1, seen);
		chk("rx_data", b, got);
		if (!seen)
			complete_run();
	endtask
	task automatic t_tx(input logic [7:0] b, input int p);
		logic [7:0] got;
		logic       ok;
		fork
			u_dbg_host_model.recv_byte(p, got, ok);
			begin
				tx_data = b;
				tx_valid = 1'b1;
				for (int k = 0; k < 50 && !tx_ready; k++)
					cyc(1);
				cyc(1);
				tx_valid = 1'b0;
			end
		join
		chk("tx_frame", 1, ok);
		chk("tx_data", b, got);
		if (!ok)
			complete_run();
	endtask
	// overflow leaves the rate unset; a rate of clock / 500 still locks
	task automatic t_ovf;
		u_dbg_host_model.hold_low(4200);
		cyc(20);
		chk("ovf_unlocked", 0, baud_locked);
		t_lock(500);
		t_rx(8'h5A, 500);
	endtask
	task automatic t_break(input int p);
		int n;
		enter();
		n = 0;
		fork
			u_dbg_host_model.hold_low(12 * p);
			for (int k = 0; k < 12 * p + 4300; k++) begin
				cyc(1);
				n += debug_serial_pin_oe;
			end
		join
		chk("break_len", 16'(BREAK_TX_CLKS), 16'(n));
		chk("unlocked", 0, baud_locked);
		chk("mode_kept", 1, debug_mode);
		t_lock(8);
		leave();
	endtask
	task automatic t_modes;
		halt_mode = 1'b1;
		wdt_enable = 1'b1;
		enter();
		chk("halt_exit", 1, halt_exit);
		cyc(1);
		chk("debug_mode", 1, debug_mode);
		chk("fetch_stop", 1, fetch_stop);
		chk("wdt_refresh", 1, wdt_refresh);
		exec_req = 1'b1;
		cyc(1);
		chk("exec_grant", 1, exec_grant);
		exec_req = 1'b0;
		halt_mode = 1'b0;
		leave();
		pulse(break_instruction);
		cyc(1);
		chk("brk_off", 0, debug_mode);
		breakpoint_en = 1'b1;
		pulse(break_instruction);
		cyc(1);
		chk("brk_on", 1, debug_mode);
		leave();
		counter_wdata = 16'h1234;
		pulse(counter_wr);
		prog_counter = 16'h1234;
		match_break_en = 1'b1;
		cyc(2);
		chk("match", 1, debug_mode);
		match_break_en = 1'b0;
		leave();
		counter_wdata = 16'h0005;
		pulse(counter_wr);
		countdown_break_en = 1'b1;
		cyc(2);
		chk("count_early", 0, debug_mode);
		cyc(6);
		chk("countdown", 1, debug_mode);
		chk("count_zero", 0, debug_counter);
		countdown_break_en = 1'b0;
		leave();
	endtask
	// host pulls low inside a released bit: collision, abort, break back
	task automatic t_coll;
		int a;
		a = 0;
		tx_data = 8'hFF;
		tx_valid = 1'b1;
		cyc(1);
		tx_valid = 1'b0;
		fork
			begin
				cyc(9);
				u_dbg_host_model.hold_low(6);
			end
			for (int k = 0; k < 4200; k++) begin
				cyc(1);
				a += cmd_abort;
			end
		join
		chk("coll_abort", 1, 16'(a));
		chk("coll_unlocked", 0, baud_locked);
		t_lock(8);
	endtask
	task automatic t_stop;
		stop_mode = 1'b1;
		cyc(1);
		chk("periph_run", 0, periph_run);
		fork
			u_dbg_host_model.hold_low(8);
			begin
				cyc(6);
				chk("sys_reset_req", 1, sys_reset_req);
			end
		join
		stop_mode = 1'b0;
		cyc(120);
	endtask
	task automatic t_strap;
		enter();
		reset();
		chk("reset_exit", 0, debug_mode);
		fork
			u_dbg_host_model.hold_low(10);
			reset();
		join
		cyc(4);
		chk("strap", 1, debug_mode);
	endtask
	initial begin
		failures = 0;
		comparisons = 0;
		{srst, tx_valid, ctrl_wr, debug_mode_request_bit} = '0;
		{breakpoint_en, break_instruction, match_break_en} = '0;
		{counter_wr, countdown_break_en, stop_mode, halt_mode} = '0;
		{exec_req, wdt_enable, tx_data, prog_counter, counter_wdata} = '0;
		reset();
		chk("rst_mode", 0, debug_mode);
		chk("rst_locked", 0, baud_locked);
		chk("rst_counter", 0, debug_counter);
		cyc(5);
		t_ovf();
		t_break(500);
		t_rx(8'hA5, 8);
		t_tx(8'h3C, 8);
		t_tx(8'hA1, 8);
		t_modes();
		t_coll();
		t_stop();
		t_strap();
		complete_run();
	end
endmodule // tb_dbg_link
bind dbg_link dbg_link_assertions u_dbg_link_assertions (.core_clk, .srst,
	.debug_serial_pin_in, .debug_serial_pin_out, .debug_serial_pin_oe,
	.tx_valid, .tx_ready, .cmd_abort, .baud_locked, .ctrl_wr,
	.debug_mode_request_bit, .debug_mode, .breakpoint_en,
	.break_instruction, .match_break_en, .countdown_break_en,
	.prog_counter, .debug_counter, .stop_mode, .halt_mode, .halt_exit,
	.exec_req, .fetch_stop, .periph_run, .wdt_enable, .wdt_refresh,
	.sys_reset_req);
